//--- lcgs_regs.vh
// register offsets, field positions and reset values of the gate select block
`ifndef LCGS_REGS_VH
`define LCGS_REGS_VH

`define LCGS_ADDR_W          8
`define LCGS_OFF_GATE1_SEL   8'h00
`define LCGS_OFF_GATE2_SEL   8'h04
`define LCGS_OFF_GATE3_SEL   8'h08
`define LCGS_OFF_GATE4_SEL   8'h0c
`define LCGS_OFF_OUT_MIRROR  8'h10
`define LCGS_SEL_RESET       8'h00
`define LCGS_MIRROR_RESET    8'h00
`define LCGS_BIT_CELL1_COPY  0
`define LCGS_BIT_CELL2_COPY  1
`define LCGS_RESP_OKAY       2'b00
`define LCGS_RESP_SLVERR     2'b10

`endif

//--- lcgs_gate.v
// one gate: and-or of selected true and inverted data inputs
module lcgs_gate (
    input  wire [7:0] sel,
    input  wire [3:0] data_in,
    output wire       gate_node
);
    wire [7:0] term;
    genvar i;
    // odd bit picks true form, even bit picks inverted form
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_in
            assign term[2*i+1] = sel[2*i+1] & data_in[i];
            assign term[2*i]   = sel[2*i] & ~data_in[i];
        end
    endgenerate
    assign gate_node = |term;
endmodule // lcgs_gate

//--- lcgs_top.v
// gate input select registers and cell output mirror behind an AXI4-Lite slave
`include "lcgs_regs.vh"
module lcgs_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [3:0]  data_in,
    input  wire        cell1_result,
    input  wire        cell2_result,
    output reg  [3:0]  gate_nodes
);
    // select registers, index 0..3 is gate 1..4, no reset on purpose
    reg  [7:0]  sel_q [0:3];
    // mirror of both cell results
    reg  [7:0]  mirror_q;
    reg  [7:0]  mirror_d;
    // write address and data held between take and commit
    reg  [7:0]  aw_addr_q;
    reg  [7:0]  aw_addr_d;
    reg         aw_have_q;
    reg         aw_have_d;
    reg  [31:0] w_data_q;
    reg  [31:0] w_data_d;
    reg  [3:0]  w_strb_q;
    reg  [3:0]  w_strb_d;
    reg         w_have_q;
    reg         w_have_d;
    // next values of the bus outputs and the gate outputs
    reg         awready_d;
    reg         wready_d;
    reg         bvalid_d;
    reg  [1:0]  bresp_d;
    reg         arready_d;
    reg         rvalid_d;
    reg  [31:0] rdata_d;
    reg  [1:0]  rresp_d;
    reg  [3:0]  gate_nodes_d;
    // handshakes and decoded addresses
    wire [3:0]  gate_raw;
    wire        aw_take;
    wire        w_take;
    wire        ar_take;
    wire        b_done;
    wire        r_done;
    wire        do_write;
    wire [2:0]  wr_slot;
    wire [2:0]  rd_slot;
    wire        wr_hit;
    wire        rd_hit;
    wire [1:0]  wr_idx;
    wire [1:0]  rd_idx;
    wire        wr_mirror;
    wire        rd_mirror;
    wire        low_lane;
    wire        sel_we;
    wire [7:0]  rd_sel;

    // map a byte address to a select index, bit 2 flags a hit
    function [2:0] sel_decode;
        input [7:0] addr;
        begin
            case (addr)
                `LCGS_OFF_GATE1_SEL: sel_decode = 3'h4;
                `LCGS_OFF_GATE2_SEL: sel_decode = 3'h5;
                `LCGS_OFF_GATE3_SEL: sel_decode = 3'h6;
                `LCGS_OFF_GATE4_SEL: sel_decode = 3'h7;
                default:             sel_decode = 3'h0;
            endcase
        end
    endfunction

    // true for the byte address of the output mirror
    function is_mirror;
        input [7:0] addr;
        begin
            is_mirror = (addr == `LCGS_OFF_OUT_MIRROR);
        end
    endfunction

    // handshakes of the five channels
    assign aw_take  = s_axi_awvalid && s_axi_awready;
    assign w_take   = s_axi_wvalid && s_axi_wready;
    assign ar_take  = s_axi_arvalid && s_axi_arready;
    assign b_done   = s_axi_bvalid && s_axi_bready;
    assign r_done   = s_axi_rvalid && s_axi_rready;

    // commit once both halves are in and the last response is gone
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

    // address decode for the held write and the incoming read
    assign wr_slot   = sel_decode(aw_addr_q);
    assign rd_slot   = sel_decode(s_axi_araddr);
    assign wr_hit    = wr_slot[2];
    assign rd_hit    = rd_slot[2];
    assign wr_idx    = wr_slot[1:0];
    assign rd_idx    = rd_slot[1:0];
    assign wr_mirror = is_mirror(aw_addr_q);
    assign rd_mirror = is_mirror(s_axi_araddr);

    // only the lowest byte lane carries a select value
    assign low_lane  = w_strb_q[0];
    assign sel_we    = do_write && wr_hit && low_lane;
    assign rd_sel    = sel_q[rd_idx];

    // gates: one instance per gate, same bit layout for all
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_gate
            lcgs_gate u_gate (
                .sel       (sel_q[g]),
                .data_in   (data_in),
                .gate_node (gate_raw[g])
            );
        end
    endgenerate

    // gate outputs follow the selects one clock after the write
    always @* begin
        gate_nodes_d = gate_raw;
    end

    // registered gate outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            gate_nodes <= 4'h0;
        end else begin
            gate_nodes <= gate_nodes_d;
        end
    end

    // mirror next value, upper bits forced to zero
    always @* begin
        mirror_d = `LCGS_MIRROR_RESET;
        mirror_d[`LCGS_BIT_CELL1_COPY] = cell1_result;
        mirror_d[`LCGS_BIT_CELL2_COPY] = cell2_result;
    end

    // mirror register, one clock behind the cells
    always @(posedge aclk) begin
        if (!aresetn) begin
            mirror_q <= `LCGS_MIRROR_RESET;
        end else begin
            mirror_q <= mirror_d;
        end
    end

    // write address next values: take, hold, drop on commit
    always @* begin
        aw_addr_d = aw_addr_q;
        aw_have_d = aw_have_q;
        awready_d = s_axi_awready;
        if (aw_take) begin
            aw_addr_d = s_axi_awaddr;
            aw_have_d = 1'b1;
            awready_d = 1'b0;
        end
        if (do_write) begin
            aw_have_d = 1'b0;
        end
        if (b_done) begin
            awready_d = 1'b1;
        end
    end

    // write data next values, independent of the address channel
    always @* begin
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        w_have_d = w_have_q;
        wready_d = s_axi_wready;
        if (w_take) begin
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
            w_have_d = 1'b1;
            wready_d = 1'b0;
        end
        if (do_write) begin
            w_have_d = 1'b0;
        end
        if (b_done) begin
            wready_d = 1'b1;
        end
    end

    // write address and data registers, ready high when idle
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
        end else begin
            s_axi_awready <= awready_d;
            s_axi_wready  <= wready_d;
            aw_have_q     <= aw_have_d;
            w_have_q      <= w_have_d;
            aw_addr_q     <= aw_addr_d;
            w_data_q      <= w_data_d;
            w_strb_q      <= w_strb_d;
        end
    end

    // write response next values, unmapped address answers slverr
    always @* begin
        bvalid_d = s_axi_bvalid;
        bresp_d  = s_axi_bresp;
        if (do_write) begin
            bvalid_d = 1'b1;
            if (wr_hit || wr_mirror) begin
                bresp_d = `LCGS_RESP_OKAY;
            end else begin
                bresp_d = `LCGS_RESP_SLVERR;
            end
        end else if (b_done) begin
            bvalid_d = 1'b0;
        end
    end

    // write response registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `LCGS_RESP_OKAY;
        end else begin
            s_axi_bvalid <= bvalid_d;
            s_axi_bresp  <= bresp_d;
        end
    end

    // select storage, bus reset leaves it alone so values survive it
    always @(posedge aclk) begin
        if (sel_we) begin
            sel_q[wr_idx] <= w_data_q[7:0];
        end
    end

    // read next values, answer one clock after the address is taken
    always @* begin
        arready_d = s_axi_arready;
        rvalid_d  = s_axi_rvalid;
        rdata_d   = s_axi_rdata;
        rresp_d   = s_axi_rresp;
        if (ar_take) begin
            arready_d = 1'b0;
            rvalid_d  = 1'b1;
            rresp_d   = `LCGS_RESP_OKAY;
            if (rd_hit) begin
                rdata_d = {24'h000000, rd_sel};
            end else if (rd_mirror) begin
                rdata_d = {24'h000000, mirror_q};
            end else begin
                rdata_d = 32'h0000_0000;
                rresp_d = `LCGS_RESP_SLVERR;
            end
        end else if (r_done) begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end
    end

    // read channel registers, one request at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `LCGS_RESP_OKAY;
        end else begin
            s_axi_arready <= arready_d;
            s_axi_rvalid  <= rvalid_d;
            s_axi_rdata   <= rdata_d;
            s_axi_rresp   <= rresp_d;
        end
    end
endmodule // lcgs_top

//--- lcgs_top_sva.sv
// concurrent checks on the read channel, output mirror and reset of the gate select block
`include "lcgs_regs.vh"
module lcgs_top_sva (
    input wire        aclk,
    input wire        aresetn,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        cell1_result,
    input wire        cell2_result,
    input wire [3:0]  gate_nodes
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // read address taken, any place and the mirror alone
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire mir_rd  = ar_take && s_axi_araddr == `LCGS_OFF_OUT_MIRROR;
    a_mirror_cell1: assert property (mir_rd |=> s_axi_rdata[0] == $past(cell1_result, 2))
        else $error("mirror bit 0 wrong");
    a_mirror_cell2: assert property (mir_rd |=> s_axi_rdata[1] == $past(cell2_result, 2))
        else $error("mirror bit 1 wrong");
    a_mirror_upper: assert property (mir_rd |=> s_axi_rdata[31:2] == 30'h0)
        else $error("mirror upper bits set");
    a_unmapped_read: assert property (ar_take && s_axi_araddr > 8'h13 |=>
        s_axi_rresp == `LCGS_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("no slave error");
    a_read_answer: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read upper bits set");
    a_reset_idle: assert property ($rose(aresetn) |-> !s_axi_rvalid && gate_nodes == 4'h0)
        else $error("outputs busy after reset");
endmodule // lcgs_top_sva
bind lcgs_top lcgs_top_sva chk_i (.*);

//--- test_logic_cell_gate_select.sv
// bench for the gate select registers, gate outputs and cell output mirror
`include "lcgs_regs.vh"
module test_logic_cell_gate_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic cell1_result = 1'b0, cell2_result = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, rd;
    logic [3:0] s_axi_wstrb = 4'h1, data_in = 4'h0;
    logic [1:0] rs, bs;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [3:0] gate_nodes;
    int mismatches = 0, checks_done = 0;
    // rows: select value, data inputs, expected output of every gate
    logic [12:0] rows [10] = '{{8'h80, 4'h8, 1'b1}, {8'h80, 4'h7, 1'b0}, {8'h40, 4'h7, 1'b1},
        {8'h40, 4'h8, 1'b0}, {8'h20, 4'h4, 1'b1}, {8'h10, 4'hb, 1'b1}, {8'h08, 4'h2, 1'b1},
        {8'h04, 4'hd, 1'b1}, {8'h02, 4'h1, 1'b1}, {8'h55, 4'he, 1'b1}};
    lcgs_top dut (.*);
    always #2 aclk = ~aclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one register write, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        bs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // one register read, ready raised late so the answer must stand
    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #20000;
        mismatches++;
        stop_test;
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            data_in <= rows[i][4:1];
            for (int g = 0; g < 4; g++) wr(8'(g * 4), rows[i][12:5]);
            @(negedge aclk);
            chk(gate_nodes, {4{rows[i][0]}});
            rdr(`LCGS_OFF_GATE3_SEL);
            chk(rd, rows[i][12:5]);
        end
        // selects 0, 2, 1, 1: only gate 2 passes data input 1
        data_in <= 4'h1;
        for (int g = 0; g < 4; g++) wr(8'(g * 4), 8'(g == 1 ? 2 : g > 1));
        @(negedge aclk);
        chk(gate_nodes, 4'h2);
        @(posedge aclk);
        cell1_result <= 1'b1;
        wr(`LCGS_OFF_OUT_MIRROR, 8'hff);
        chk(bs, `LCGS_RESP_OKAY);
        rdr(`LCGS_OFF_OUT_MIRROR);
        chk(rd, 32'h1);
        cell1_result <= 1'b0;
        cell2_result <= 1'b1;
        rdr(`LCGS_OFF_OUT_MIRROR);
        chk(rd, 32'h2);
        rdr(8'h20);
        chk(rs, `LCGS_RESP_SLVERR);
        chk(rd, 32'h0);
        wr(8'h20, 8'h00);
        chk(bs, `LCGS_RESP_SLVERR);
        // write with the low lane off must leave gate 2 alone
        s_axi_wstrb <= 4'h0;
        wr(`LCGS_OFF_GATE2_SEL, 8'hff);
        s_axi_wstrb <= 4'h1;
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk(gate_nodes, 4'h0);
        chk({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid}, 5'h1c);
        rdr(`LCGS_OFF_GATE2_SEL);
        chk(rd, 32'h2);
        stop_test;
    end
endmodule // test_logic_cell_gate_select
